/* hdl/bsa_pkg.sv */
// Constants, encodings and register map of the BCD stack arithmetic unit.
// Assumes one 200 MHz clock and an AXI4-Lite register port.
package bsa_pkg;

    // ****************************************************************
    // Operation codes issued by the sequencer
    // ****************************************************************
    typedef enum logic [2:0] {
        OP_LOAD                = 3'b000,
        OP_DIVIDE_BY_BIT_RANGE = 3'b001,
        OP_ADD_STACK_TOP       = 3'b010,
        OP_SUBTRACT_STACK_TOP  = 3'b011,
        OP_MULTIPLY_STACK_TOP  = 3'b100
    } bsa_op_t;

    // Write channel progress of the register slave
    typedef enum logic [0:0] {
        WR_COLLECT = 1'b0,
        WR_RESP    = 1'b1
    } bsa_wr_t;

    // ****************************************************************
    // Sizes and decimal limits
    // ****************************************************************
    localparam int          STACK_DEPTH = 8;
    localparam logic [4:0]  LEN_MIN     = 5'h01;
    localparam logic [4:0]  LEN_MAX     = 5'h10;
    localparam logic [31:0] DEC_LIMIT   = 32'h05F5E100; // Ten to the eight
    localparam logic [31:0] DEC_HALF    = 32'h00002710; // Ten to the four

    // ****************************************************************
    // Register byte addresses
    // ****************************************************************
    localparam logic [7:0] ADDR_ACC        = 8'h00;
    localparam logic [7:0] ADDR_FLAGS      = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK   = 8'h0C;
    localparam logic [7:0] ADDR_CTRL       = 8'h10;
    localparam logic [7:0] ADDR_STACK_TOP  = 8'h14;

    // Flag bit positions in the flags register
    localparam int FLAG_ZERO     = 0;
    localparam int FLAG_CARRY16  = 1;
    localparam int FLAG_CARRY32  = 2;
    localparam int FLAG_BORROW16 = 3;
    localparam int FLAG_BORROW32 = 4;
    localparam int FLAG_NEG      = 5;
    localparam int FLAG_INVALID  = 6;

    // Interrupt status bit positions
    localparam int IRQ_DONE    = 0;
    localparam int IRQ_INVALID = 1;
    localparam int IRQ_REFUSED = 2;

    // Reset values and response codes
    localparam logic [6:0]  FLAGS_RESET = 7'h00;
    localparam logic [2:0]  MASK_RESET  = 3'h0;
    localparam logic        CTRL_RESET  = 1'b1;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

/* hdl/bsa_unit.sv */
// BCD arithmetic datapath: accumulator, eight-level stack, status flags.
// Assumes a sequencer that issues one operation per op_valid cycle and
// an AXI4-Lite master for the register port; all on one clock.
//
// Functional notes
// - Divide uses accumulator as four-digit dividend.
// - Bit range length must be one to sixteen.
// - Quotient to accumulator, remainder to stack top.
// - Add stack top to accumulator, eight digits.
// - Add, subtract, multiply pop stack upward.
// - Subtract stack top from accumulator, eight digits.
// - Multiply four-digit stack top by four-digit accumulator.
// - Load pushes old accumulator onto stack.
// - Zero flag when arithmetic result is zero.
// - Borrow out of low four digits flagged.
// - Borrow out of eight digits flagged separately.
// - Add flags carry from sixteen and thirty-two bits.
// - Negative flag when accumulator result negative.
// - Non-BCD operand digit sets invalid flag.
// - Flags hold until next operation touching them.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps

module bsa_unit (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic [2:0]         s_axi_awprot,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic [2:0]         s_axi_arprot,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    input  wire logic               op_valid,
    input  wire bsa_pkg::bsa_op_t   op_code,
    input  wire logic [31:0]        op_load_value,
    input  wire logic [15:0]        op_bit_value,
    input  wire logic [4:0]         op_bit_len,
    output logic                    op_done,
    output logic [31:0]             acc_value,
    output logic                    zero_flag,
    output logic                    carry16_flag,
    output logic                    carry32_flag,
    output logic                    borrow16_flag,
    output logic                    borrow32_flag,
    output logic                    negative_flag,
    output logic                    invalid_bcd_flag,
    output logic                    irq
);
    import bsa_pkg::*;

    // ****************************************************************
    // Decimal helpers
    // ****************************************************************
    // Packed BCD to binary, digit by digit, most significant first
    function automatic logic [31:0] bcd2bin(input logic [31:0] b);
        logic [31:0] r;
        r = '0;
        for (int i = 7; i >= 0; i--) begin
            r = (r << 3) + (r << 1) + {28'h0, b[i*4 +: 4]};
        end
        return r;
    endfunction

    // Binary below ten to the eight back to packed BCD
    function automatic logic [31:0] bin2bcd(input logic [31:0] v);
        logic [31:0] d;
        d = '0;
        for (int i = 31; i >= 0; i--) begin
            for (int j = 0; j < 8; j++) begin
                if (d[j*4 +: 4] > 4'h4) begin
                    d[j*4 +: 4] = d[j*4 +: 4] + 4'h3;
                end
            end
            d = {d[30:0], v[i]};
        end
        return d;
    endfunction

    // Any nibble above nine is not a decimal digit
    function automatic logic bcd_bad(input logic [31:0] b);
        logic r;
        r = 1'b0;
        for (int j = 0; j < 8; j++) begin
            if (b[j*4 +: 4] > 4'h9) begin
                r = 1'b1;
            end
        end
        return r;
    endfunction

    // Register map decode, shared by the read and write paths
    function automatic logic addr_known(input logic [7:0] a);
        return a == ADDR_ACC || a == ADDR_FLAGS || a == ADDR_IRQ_STATUS ||
               a == ADDR_IRQ_MASK || a == ADDR_CTRL ||
               a == ADDR_STACK_TOP;
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [31:0]                  acc;      // Accumulator
        logic [STACK_DEPTH-1:0][31:0] stack;    // Level 1 is index 0
        logic [6:0]                   flags;    // Status flags
        logic [2:0]                   irq_st;   // Sticky events
        logic [2:0]                   irq_mask; // Event enables
        logic                         enable;   // Operations accepted
        logic                         done;     // Operation finished
        logic                         irq;      // Interrupt level
        bsa_wr_t                      wr;       // Write progress
        logic                         aw_have;  // Address held
        logic                         w_have;   // Data held
        logic [7:0]                   aw_addr;
        logic [31:0]                  w_data;
        logic                         w_lane0;  // Low byte strobe
        logic                         bvalid;
        logic [1:0]                   bresp;
        logic                         rvalid;
        logic [31:0]                  rdata;
        logic [1:0]                   rresp;
    } bsa_state_t;

    bsa_state_t st;        // Registered state
    bsa_state_t next_st;   // Next state

    logic [31:0] a_bin;    // Accumulator in binary
    logic [31:0] s_bin;    // Stack top in binary
    logic [31:0] a_lo;     // Low four digits, binary
    logic [31:0] s_lo;
    logic [15:0] div_bcd;  // Divisor bits within the range
    logic [31:0] div_bin;
    logic [31:0] sum;
    logic [31:0] mul_bin;
    logic        take;     // Operation accepted this cycle
    logic        len_ok;   // Divide length within range
    logic        bad;      // Operand holds a non-decimal digit
    logic        arith;    // Operation is one of the four

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    // Whole datapath and register slave in one process
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        a_bin = bcd2bin(st.acc);
        s_bin = bcd2bin(st.stack[0]);
        a_lo = bcd2bin({16'h0, st.acc[15:0]});
        s_lo = bcd2bin({16'h0, st.stack[0][15:0]});
        div_bcd = op_bit_value & 16'((17'h1 << op_bit_len) - 17'h1);
        div_bin = bcd2bin({16'h0, div_bcd});
        sum = a_bin + s_bin;
        mul_bin = a_lo * s_lo;
        take = op_valid && st.enable;
        len_ok = op_bit_len >= LEN_MIN && op_bit_len <= LEN_MAX;
        arith = op_code != OP_LOAD;
        bad = 1'b0;

        // Operand check; only the digits an operation reads count
        case (op_code)
            OP_DIVIDE_BY_BIT_RANGE:
                bad = bcd_bad({16'h0, st.acc[15:0]}) ||
                      bcd_bad({16'h0, div_bcd});
            OP_MULTIPLY_STACK_TOP:
                bad = bcd_bad({16'h0, st.acc[15:0]}) ||
                      bcd_bad({16'h0, st.stack[0][15:0]});
            OP_ADD_STACK_TOP, OP_SUBTRACT_STACK_TOP:
                bad = bcd_bad(st.acc) || bcd_bad(st.stack[0]);
            default:
                bad = 1'b0;
        endcase

        if (take) begin
            next_st.done = 1'b1;
            if (op_code == OP_LOAD) begin
                // Push everything down, new value into accumulator
                for (int i = STACK_DEPTH - 1; i > 0; i--) begin
                    next_st.stack[i] = st.stack[i-1];
                end
                next_st.stack[0] = st.acc;
                next_st.acc = op_load_value;
            end else if (op_code == OP_DIVIDE_BY_BIT_RANGE && !len_ok) begin
                // Refused length: accumulator, stack and flags unchanged; refusal event set
                next_st.irq_st[IRQ_REFUSED] = 1'b1;
            end else if (bad) begin
                // Operands are left untouched so software can inspect them
                next_st.flags[FLAG_INVALID] = 1'b1;
            end else begin
                next_st.flags[FLAG_INVALID] = 1'b0;
                next_st.flags[FLAG_NEG] = 1'b0;
                case (op_code)
                    OP_DIVIDE_BY_BIT_RANGE: begin
                        // Zero divisor gives quotient zero, dividend kept as remainder
                        if (div_bin == 32'h0) begin
                            next_st.acc = 32'h0;
                            next_st.stack[0] = {16'h0, st.acc[15:0]};
                        end else begin
                            next_st.acc = bin2bcd(a_lo / div_bin);
                            next_st.stack[0] =
                                bin2bcd(a_lo % div_bin);
                        end
                    end
                    OP_ADD_STACK_TOP: begin
                        next_st.flags[FLAG_CARRY16] =
                            (a_lo + s_lo) >= DEC_HALF;
                        next_st.flags[FLAG_CARRY32] =
                            sum >= DEC_LIMIT;
                        next_st.acc = bin2bcd(sum >= DEC_LIMIT ?
                            sum - DEC_LIMIT : sum);
                    end
                    OP_SUBTRACT_STACK_TOP: begin
                        // A negative result is kept as its ten's complement
                        next_st.flags[FLAG_BORROW16] =
                            a_lo < s_lo;
                        next_st.flags[FLAG_BORROW32] =
                            a_bin < s_bin;
                        next_st.flags[FLAG_NEG] = a_bin < s_bin;
                        next_st.acc = bin2bcd(a_bin < s_bin ?
                            a_bin + DEC_LIMIT - s_bin :
                            a_bin - s_bin);
                    end
                    OP_MULTIPLY_STACK_TOP:
                        next_st.acc = bin2bcd(mul_bin);
                    default:
                        next_st.acc = st.acc;
                endcase
                // Stack operands are consumed; deepest level is kept
                if (op_code != OP_DIVIDE_BY_BIT_RANGE) begin
                    for (int i = 0; i < STACK_DEPTH - 1; i++) begin
                        next_st.stack[i] = st.stack[i+1];
                    end
                    next_st.stack[STACK_DEPTH-1] =
                        st.stack[STACK_DEPTH-1];
                end
                next_st.flags[FLAG_ZERO] = next_st.acc == 32'h0;
            end
        end

        // Read channel: one beat at a time, arready is the idle state
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (!st.rvalid && s_axi_arvalid) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr)
                ADDR_ACC:        next_st.rdata = st.acc;
                ADDR_FLAGS:      next_st.rdata = {25'h0, st.flags};
                ADDR_IRQ_STATUS: next_st.rdata = {29'h0, st.irq_st};
                ADDR_IRQ_MASK:   next_st.rdata = {29'h0, st.irq_mask};
                ADDR_CTRL:       next_st.rdata = {31'h0, st.enable};
                ADDR_STACK_TOP:  next_st.rdata = st.stack[0];
                default:         next_st.rdata = 32'h0;
            endcase
            // Read clears status; events below still win
            if (s_axi_araddr == ADDR_IRQ_STATUS) begin
                next_st.irq_st = 3'h0;
            end
        end

        // Write channel: address and data in either order
        if (s_axi_awvalid && !st.aw_have) begin
            next_st.aw_have = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.w_have) begin
            next_st.w_have = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_lane0 = s_axi_wstrb[0];
        end
        case (st.wr)
            WR_COLLECT: begin
                if (st.aw_have && st.w_have) begin
                    next_st.wr = WR_RESP;
                    next_st.bvalid = 1'b1;
                    next_st.bresp = addr_known(st.aw_addr) ?
                                    RESP_OKAY : RESP_SLVERR;
                    if (st.w_lane0 && st.aw_addr == ADDR_IRQ_MASK) begin
                        next_st.irq_mask = st.w_data[2:0];
                    end
                    if (st.w_lane0 && st.aw_addr == ADDR_CTRL) begin
                        next_st.enable = st.w_data[0];
                    end
                end
            end
            WR_RESP: begin
                // Holding both slots blocks a second write until answered
                if (s_axi_bready) begin
                    next_st.wr = WR_COLLECT;
                    next_st.bvalid = 1'b0;
                    next_st.aw_have = 1'b0;
                    next_st.w_have = 1'b0;
                end
            end
            default:
                next_st.wr = WR_COLLECT;
        endcase

        // Events set sticky bits after any clear
        if (take) begin
            next_st.irq_st[IRQ_DONE] = 1'b1;
        end
        if (take && arith && bad &&
            (op_code != OP_DIVIDE_BY_BIT_RANGE || len_ok)) begin
            next_st.irq_st[IRQ_INVALID] = 1'b1;
        end
        if (take && op_code == OP_DIVIDE_BY_BIT_RANGE && !len_ok) begin
            next_st.irq_st[IRQ_REFUSED] = 1'b1;
        end
        next_st.irq = |(next_st.irq_st & next_st.irq_mask);
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Synchronous active-low reset to constants
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.flags <= FLAGS_RESET;
            st.irq_mask <= MASK_RESET;
            st.enable <= CTRL_RESET;
            st.wr <= WR_COLLECT;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state flops
    assign s_axi_awready    = !st.aw_have;
    assign s_axi_wready     = !st.w_have;
    assign s_axi_bvalid     = st.bvalid;
    assign s_axi_bresp      = st.bresp;
    assign s_axi_arready    = !st.rvalid;
    assign s_axi_rvalid     = st.rvalid;
    assign s_axi_rdata      = st.rdata;
    assign s_axi_rresp      = st.rresp;
    assign op_done          = st.done;
    assign acc_value        = st.acc;
    assign zero_flag        = st.flags[FLAG_ZERO];
    assign carry16_flag     = st.flags[FLAG_CARRY16];
    assign carry32_flag     = st.flags[FLAG_CARRY32];
    assign borrow16_flag    = st.flags[FLAG_BORROW16];
    assign borrow32_flag    = st.flags[FLAG_BORROW32];
    assign negative_flag    = st.flags[FLAG_NEG];
    assign invalid_bcd_flag = st.flags[FLAG_INVALID];
    assign irq              = st.irq;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic ok_op; // Accepted arithmetic with clean operands
    assign ok_op = take && arith && !bad &&
                   (op_code != OP_DIVIDE_BY_BIT_RANGE || len_ok);

    AST_DIV_SPLIT: assert property (ok_op &&
        op_code == OP_DIVIDE_BY_BIT_RANGE && div_bin != 32'h0 |=>
        bcd2bin(st.acc) * $past(div_bin) + bcd2bin(st.stack[0]) ==
        $past(a_lo))
        else $error("divide quotient and remainder inconsistent");
    AST_LEN_REFUSED: assert property (take &&
        op_code == OP_DIVIDE_BY_BIT_RANGE && !len_ok |=>
        $stable(st.acc) && $stable(st.stack) && $stable(st.flags) &&
        st.irq_st[IRQ_REFUSED])
        else $error("bad length changed state");
    AST_ADD_SUM: assert property (ok_op &&
        op_code == OP_ADD_STACK_TOP |=>
        bcd2bin(st.acc) == ($past(sum) % DEC_LIMIT) &&
        st.flags[FLAG_CARRY16] == ($past(a_lo) + $past(s_lo) >= DEC_HALF) &&
        st.flags[FLAG_CARRY32] == ($past(sum) >= DEC_LIMIT))
        else $error("add result or carry wrong");
    AST_POP: assert property (ok_op &&
        op_code != OP_DIVIDE_BY_BIT_RANGE |=>
        st.stack[0] == $past(st.stack[1]) &&
        st.stack[STACK_DEPTH-1] == $past(st.stack[STACK_DEPTH-1]))
        else $error("stack did not move up");
    AST_SUB_BORROW: assert property (ok_op &&
        op_code == OP_SUBTRACT_STACK_TOP |=>
        st.flags[FLAG_BORROW32] == ($past(a_bin) < $past(s_bin)) &&
        st.flags[FLAG_BORROW16] == ($past(a_lo) < $past(s_lo)) &&
        st.flags[FLAG_NEG] == st.flags[FLAG_BORROW32])
        else $error("borrow or sign wrong");
    AST_MUL: assert property (ok_op &&
        op_code == OP_MULTIPLY_STACK_TOP |=>
        bcd2bin(st.acc) == $past(a_lo) * $past(s_lo))
        else $error("product wrong");
    AST_PUSH: assert property (take && op_code == OP_LOAD |=>
        st.stack[0] == $past(st.acc) && $stable(st.flags))
        else $error("load did not push");
    AST_ZERO: assert property ($past(ok_op) |->
        st.flags[FLAG_ZERO] == (st.acc == 32'h0))
        else $error("zero flag wrong");
    AST_INVALID: assert property (take && arith && bad &&
        (op_code != OP_DIVIDE_BY_BIT_RANGE || len_ok) |=>
        st.flags[FLAG_INVALID] && $stable(st.acc) && $stable(st.stack) &&
        st.irq_st[IRQ_INVALID])
        else $error("invalid digit not flagged");
    AST_IRQ: assert property (st.irq == |(st.irq_st & st.irq_mask))
        else $error("interrupt level wrong");

endmodule // bsa_unit

/* testbench/bcd_stack_arith_unit_bench.sv */
// Bench: AXI4-Lite tasks plus sequencer model drive the unit.
// Assumes 200 MHz clock and a synchronous active-low reset.
`timescale 1ns/1ps
module bcd_stack_arith_unit_bench;
    import bsa_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, op_valid, op_done;
    logic zero_flag, carry16_flag, carry32_flag, borrow16_flag, irq;
    logic borrow32_flag, negative_flag, invalid_bcd_flag, done_seen;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    logic [3:0]  s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, acc_value, op_load_value, rd;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] op_bit_value;
    logic [4:0]  op_bit_len;
    logic [6:0]  fl;
    bsa_op_t     op_code;
    int          mismatches, compares;
    assign fl = {invalid_bcd_flag, negative_flag, borrow32_flag,
                 borrow16_flag, carry32_flag, carry16_flag, zero_flag};
    bsa_unit dut (.*);
    bsa_seq_model seq (.*);
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, RESP_OKAY);
    endtask
    task axr(input logic [7:0] a, input logic [1:0] resp);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        chk(s_axi_rresp, resp);
    endtask
    task op(input bsa_op_t c, input logic [31:0] v, input logic [15:0] b,
            input logic [4:0] n);
        seq.issue(c, v, b, n, 1);
        chk(done_seen, 1'b1);
    endtask
    // Load s then a, so acc=a and level 1=s, then run c
    task ar(input bsa_op_t c, input logic [31:0] a, input logic [31:0] s,
            input logic [31:0] e, input logic [6:0] f);
        op(OP_LOAD, s, 16'h0, 5'h01);
        op(OP_LOAD, a, 16'h0, 5'h01);
        op(c, 32'h0, 16'h0, 5'h01);
        chk(acc_value, e);
        chk(fl, f);
    endtask
    initial begin
        #100000;
        mismatches++;
        stop_test();
    end
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
        {s_axi_awprot, s_axi_arprot, s_axi_wdata} = 38'h0;
        s_axi_wstrb = 4'hF;
        {aresetn, mismatches, compares} = 65'h0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        op(OP_LOAD, 32'h1111, 16'h0, 5'h01);
        ar(OP_ADD_STACK_TOP, 32'h5678, 32'h1234, 32'h6912, 7'h00);
        axr(ADDR_STACK_TOP, RESP_OKAY);
        chk(rd, 32'h1111);
        ar(OP_ADD_STACK_TOP, 32'h9999, 32'h1, 32'h10000, 7'h02);
        ar(OP_ADD_STACK_TOP, 32'h99999999, 32'h1, 32'h0, 7'h07);
        ar(OP_SUBTRACT_STACK_TOP, 32'h5, 32'h7, 32'h99999998,
           7'h3E);
        ar(OP_SUBTRACT_STACK_TOP, 32'h10000, 32'h1, 32'h9999,
           7'h0E);
        ar(OP_MULTIPLY_STACK_TOP, 32'h12, 32'h34, 32'h408, 7'h0E);
        ar(OP_ADD_STACK_TOP, 32'h1A, 32'h1, 32'h1A, 7'h4E);
        $display("arithmetic tests done");
        op(OP_LOAD, 32'h0100, 16'h0, 5'h01);
        op(OP_DIVIDE_BY_BIT_RANGE, 32'h0, 16'hFF07, 5'h04);
        chk(acc_value, 32'h14);
        axr(ADDR_STACK_TOP, RESP_OKAY);
        chk(rd, 32'h2);
        op(OP_DIVIDE_BY_BIT_RANGE, 32'h0, 16'h0002, 5'h10);
        chk(acc_value, 32'h7);
        op(OP_DIVIDE_BY_BIT_RANGE, 32'h0, 16'h0002, 5'h11);
        chk(acc_value, 32'h7);
        // Disabled unit ignores a request: no done pulse, no push
        axw(ADDR_CTRL, 32'h0);
        seq.issue(OP_LOAD, 32'h5, 16'h0, 5'h01, 1);
        chk(done_seen, 1'b0);
        chk(acc_value, 32'h7);
        axw(ADDR_CTRL, 32'h1);
        // Zero divisor: quotient zero, dividend kept as remainder
        op(OP_DIVIDE_BY_BIT_RANGE, 32'h0, 16'h0, 5'h04);
        chk(acc_value, 32'h0);
        axr(ADDR_STACK_TOP, RESP_OKAY);
        chk(rd, 32'h7);
        $display("divide tests done");
        axw(ADDR_IRQ_MASK, 32'h1);
        op(OP_LOAD, 32'h1, 16'h0, 5'h01);
        @(posedge aclk);
        #1 chk(irq, 1'b1);
        axr(ADDR_IRQ_STATUS, RESP_OKAY);
        chk(rd, 32'h7);
        repeat (2) @(posedge aclk);
        #1 chk(irq, 1'b0);
        axr(8'h40, RESP_SLVERR);
        chk(rd, 32'h0);
        $display("register tests done");
        stop_test();
    end
endmodule // bcd_stack_arith_unit_bench

/* testbench/bsa_seq_model.sv */
// Sequencer model: issues one operation and notes the done pulse.
// Assumes op_done rises at the taking edge itself.
`timescale 1ns/1ps
module bsa_seq_model (
    input  wire logic             aclk,
    input  wire logic             op_done,
    output logic                  op_valid,
    output bsa_pkg::bsa_op_t      op_code,
    output logic [31:0]           op_load_value,
    output logic [15:0]           op_bit_value,
    output logic [4:0]            op_bit_len,
    output logic                  done_seen
);
    import bsa_pkg::*;
    initial begin
        op_valid = 1'b0;
        op_code = OP_LOAD;
        op_load_value = 32'h0;
        op_bit_value = 16'h0;
        op_bit_len = 5'h01;
        done_seen = 1'b0;
    end
    // One request for one cycle; gap adds idle cycles before it
    task issue(input bsa_op_t c, input logic [31:0] v,
               input logic [15:0] b, input logic [4:0] n, input int gap);
        repeat (gap) @(posedge aclk);
        @(posedge aclk);
        op_valid <= 1'b1;
        op_code <= c;
        op_load_value <= v;
        op_bit_value <= b;
        op_bit_len <= n; // Length 1 to 16 unless a refusal is wanted
        @(posedge aclk);
        op_valid <= 1'b0;
        op_load_value <= ~v; // Stale operands never look valid
        op_bit_value <= ~b;
        #1 done_seen = op_done; // Results read before next op
    endtask
endmodule // bsa_seq_model
